// >>> rtl/heater_loop_supervisor.sv
/*
 * two-loop heater burnout supervision, halt control, input offset and
 * loop disable through the alarm-mode word, with a simple register port.
 * assumes current, pv, sensor-open and demand inputs arrive from other
 * clock domains (sampled twice) and a host with one-cycle strobes.
 */
`timescale 1ns/1ps
module heater_loop_supervisor #(
    parameter int unsigned QUAL_CYCLES = heater_loop_pkg::QUAL_CYCLES,
    parameter int unsigned LOOPS       = 2
) (
    // clock and reset
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    // register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [15:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [15:0]         reg_rdata,
    // measurement inputs from the analog front end
    input  wire logic [LOOPS*16-1:0] current_sense_transformer,
    input  wire logic [LOOPS*16-1:0] raw_pv,
    input  wire logic [LOOPS-1:0]    sensor_open,
    // control demand from the regulation algorithm
    input  wire logic [LOOPS-1:0]    output_demand,
    // outputs
    output logic      [LOOPS-1:0]    control_out,
    output logic      [LOOPS-1:0]    heater_open_alarm,
    output logic                     unit_fault_lamp,
    output logic                     irq
);

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // address of a per-loop register
    function automatic logic [7:0] loop_addr(input int unsigned lp, input logic [7:0] off);
        loop_addr = 8'(heater_loop_pkg::REG_LOOP_BASE
                    + 8'(lp) * heater_loop_pkg::LOOP_STRIDE + off);
    endfunction

    // loop disabled when both of its mode nibbles are 16#f
    function automatic logic loop_disabled(input logic [15:0] mode, input int unsigned lp);
        logic [7:0] b;
        b = (lp == 0) ? mode[15:8] : mode[7:0];
        loop_disabled = (b[7:4] == heater_loop_pkg::MODE_DISABLE)
                     && (b[3:0] == heater_loop_pkg::MODE_DISABLE);
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // host settings
    logic [15:0]                      loop_alarm_mode_select;
    logic [LOOPS-1:0]                 halt_request;
    logic [15:0]                      thresh     [LOOPS];
    logic [15:0]                      offset     [LOOPS];
    heater_loop_pkg::method_type      method     [LOOPS];
    logic [heater_loop_pkg::IRQ_BITS-1:0] irq_status;
    logic [heater_loop_pkg::IRQ_BITS-1:0] irq_enable;
    logic [heater_loop_pkg::IRQ_BITS-1:0] irq_clear;
    logic [heater_loop_pkg::IRQ_BITS-1:0] irq_event;

    // synchronised inputs
    logic [LOOPS*16-1:0] cur_s1, cur_s2, pv_s1, pv_s2;
    logic [LOOPS-1:0]    open_s1, open_s2, dem_s1, dem_s2;

    // per loop state
    logic [15:0]      pv_comp   [LOOPS];
    logic [31:0]      on_count  [LOOPS];
    logic [LOOPS-1:0] qualified;
    logic [LOOPS-1:0] sensor_err;
    logic [LOOPS-1:0] sensor_err_d;
    logic [LOOPS-1:0] open_d;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // wide values may tear on the first stage; the front end holds them
    // steady between conversions so the second stage sees a clean word
    // levels take the same two stages
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cur_s1  <= '0;
            cur_s2  <= '0;
            pv_s1   <= '0;
            pv_s2   <= '0;
            open_s1 <= '0;
            open_s2 <= '0;
            dem_s1  <= '0;
            dem_s2  <= '0;
        end
        else
        begin
            cur_s1  <= current_sense_transformer;
            cur_s2  <= cur_s1;
            pv_s1   <= raw_pv;
            pv_s2   <= pv_s1;
            open_s1 <= sensor_open;
            open_s2 <= open_s1;
            dem_s1  <= output_demand;
            dem_s2  <= dem_s1;
        end
    end

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // global settings
    // read-only offsets are ignored
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            loop_alarm_mode_select <= heater_loop_pkg::ALARM_MODE_RESET;
            halt_request           <= '0;
            irq_enable             <= '0;
        end
        else if (reg_wr)
        begin
            if (reg_addr == heater_loop_pkg::REG_ALARM_MODE)
                loop_alarm_mode_select <= reg_wdata;
            else if (reg_addr == heater_loop_pkg::REG_HALT)
                halt_request <= reg_wdata[LOOPS-1:0]; // bit0 loop1_halt_request
            else if (reg_addr == heater_loop_pkg::REG_IRQ_ENABLE)
                irq_enable <= reg_wdata[heater_loop_pkg::IRQ_BITS-1:0];
        end
    end

    // clear register is write-only: a one-cycle pulse
    always_comb
    begin
        irq_clear = '0;
        if (reg_wr && reg_addr == heater_loop_pkg::REG_IRQ_CLEAR)
            irq_clear = reg_wdata[heater_loop_pkg::IRQ_BITS-1:0];
    end

    // ------------------------------------------------------------
    // per-loop logic
    // ------------------------------------------------------------
    // one copy of the loop logic each
    genvar g;
    generate
        for (g = 0; g < LOOPS; g++)
        begin : gen_loop
            // loop-local views
            logic [15:0] cur;
            logic        run;
            logic        det_ok;
            assign cur = cur_s2[g*16 +: 16];
            // regulation runs unless halted or disabled; alarm has no say
            assign run = dem_s2[g] && !halt_request[g]
                      && !loop_disabled(loop_alarm_mode_select, g);
            // detection only in time-proportional control
            assign det_ok = (method[g] == heater_loop_pkg::METHOD_TIME_PROP);

            // per-loop settings
            // unused method code: no detection
            always_ff @(posedge sys_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    thresh[g] <= heater_loop_pkg::THRESH_RESET;
                    offset[g] <= heater_loop_pkg::OFFSET_RESET;
                    method[g] <= heater_loop_pkg::METHOD_TIME_PROP;
                end
                else if (reg_wr)
                begin
                    if (reg_addr == loop_addr(g, heater_loop_pkg::REG_THRESH))
                        thresh[g] <= reg_wdata;
                    else if (reg_addr == loop_addr(g, heater_loop_pkg::REG_OFFSET))
                        offset[g] <= reg_wdata;
                    else if (reg_addr == loop_addr(g, heater_loop_pkg::REG_METHOD))
                        method[g] <= heater_loop_pkg::method_type'(reg_wdata[1:0]);
                end
            end

            // offset-corrected pv, two's complement add over full range
            // wraps at 16 bits
            always_ff @(posedge sys_clk or negedge rst_b)
            begin
                if (!rst_b)
                    pv_comp[g] <= '0;
                else
                    pv_comp[g] <= 16'(pv_s2[g*16 +: 16] + offset[g]);
            end

            // continuous-on timer; any off cycle starts it again
            // halt also counts as output off
            always_ff @(posedge sys_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    on_count[g]  <= '0;
                    qualified[g] <= 1'b0;
                end
                else if (!run)
                begin
                    on_count[g]  <= '0;
                    qualified[g] <= 1'b0;
                end
                else if (on_count[g] < QUAL_CYCLES)
                    on_count[g] <= on_count[g] + 32'd1;
                else
                    qualified[g] <= 1'b1; // strictly more than 200 ms
            end

            // latched burnout alarm; zero threshold releases it
            // disable and zero win over sets
            always_ff @(posedge sys_clk or negedge rst_b)
            begin
                if (!rst_b)
                    heater_open_alarm[g] <= 1'b0;
                else if (loop_disabled(loop_alarm_mode_select, g))
                    heater_open_alarm[g] <= 1'b0; // alarms suppressed
                else if (thresh[g] == heater_loop_pkg::THRESH_OFF)
                    heater_open_alarm[g] <= 1'b0;
                else if (thresh[g] >= heater_loop_pkg::THRESH_FORCE)
                    heater_open_alarm[g] <= 1'b1;
                else if (det_ok && qualified[g] && run && cur < thresh[g])
                    heater_open_alarm[g] <= 1'b1;
            end

            // sensor error unless loop disabled
            assign sensor_err[g] = open_s2[g]
                                && !loop_disabled(loop_alarm_mode_select, g);

            // control output register
            // alarm has no input here
            always_ff @(posedge sys_clk or negedge rst_b)
            begin
                if (!rst_b)
                    control_out[g] <= 1'b0;
                else
                    control_out[g] <= run;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // fault lamp and interrupts
    // ------------------------------------------------------------
    // lamp follows any unsuppressed sensor error
    // disabled loops are masked
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            unit_fault_lamp <= 1'b0;
        else
            unit_fault_lamp <= |sensor_err;
    end

    // rising edges of alarm and sensor error are the events
    // reset to idle: no false edge
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            open_d       <= '0;
            sensor_err_d <= '0;
        end
        else
        begin
            open_d       <= heater_open_alarm;
            sensor_err_d <= sensor_err;
        end
    end

    // one-cycle events per loop
    always_comb
    begin
        irq_event = '0;
        for (int i = 0; i < LOOPS; i++)
        begin
            irq_event[2*i]   = heater_open_alarm[i] && !open_d[i];
            irq_event[2*i+1] = sensor_err[i] && !sensor_err_d[i];
        end
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            irq_status <= '0;
        else
            irq_status <= (irq_status & ~irq_clear) | irq_event;
    end

    // irq from next status: no lag
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            irq <= 1'b0;
        else
            irq <= |(((irq_status & ~irq_clear) | irq_event) & irq_enable);
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------
    // status word of one loop
    // unlisted bits read zero
    function automatic logic [15:0] status_word(input int unsigned lp);
        logic [15:0] s;
        s = '0;
        s[heater_loop_pkg::ST_OPEN_BIT]   = heater_open_alarm[lp];
        s[heater_loop_pkg::ST_OUTPUT_BIT] = control_out[lp];
        s[heater_loop_pkg::ST_STOP_BIT]   = halt_request[lp];
        s[heater_loop_pkg::ST_SENSOR_BIT] = sensor_err[lp];
        status_word = s;
    endfunction

    // unmapped addresses read zero; data valid only the cycle after
    always_ff @(posedge sys_clk or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= '0;
        else if (!reg_rd)
            reg_rdata <= '0;
        else
        begin
            reg_rdata <= '0;
            if (reg_addr == heater_loop_pkg::REG_ALARM_MODE)
                reg_rdata <= loop_alarm_mode_select;
            else if (reg_addr == heater_loop_pkg::REG_HALT)
                reg_rdata <= 16'(halt_request);
            else if (reg_addr == heater_loop_pkg::REG_IRQ_STATUS)
                reg_rdata <= 16'(irq_status);
            else if (reg_addr == heater_loop_pkg::REG_IRQ_ENABLE)
                reg_rdata <= 16'(irq_enable);
            else if (reg_addr == heater_loop_pkg::REG_FAULT)
                reg_rdata <= 16'(unit_fault_lamp);
            // per-loop registers
            for (int i = 0; i < LOOPS; i++)
            begin
                if (reg_addr == loop_addr(i, heater_loop_pkg::REG_THRESH))
                    reg_rdata <= thresh[i];
                else if (reg_addr == loop_addr(i, heater_loop_pkg::REG_OFFSET))
                    reg_rdata <= offset[i];
                else if (reg_addr == loop_addr(i, heater_loop_pkg::REG_CURRENT))
                    reg_rdata <= cur_s2[i*16 +: 16];
                else if (reg_addr == loop_addr(i, heater_loop_pkg::REG_PV))
                    reg_rdata <= pv_comp[i];
                else if (reg_addr == loop_addr(i, heater_loop_pkg::REG_STATUS))
                    reg_rdata <= status_word(i);
                else if (reg_addr == loop_addr(i, heater_loop_pkg::REG_METHOD))
                    reg_rdata <= 16'(method[i]);
            end
        end
    end

endmodule

// >>> rtl/heater_loop_pkg.sv
/*
 * constants for the two-loop heater supervision block: register offsets,
 * field positions, reset values, threshold codes and qualification timing.
 * assumes a 40 MHz system clock and currents coded in 0.1 A steps.
 */
package heater_loop_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned QUAL_TIME_MS    = 200;
    // more than 200 ms: the count must be exceeded, so one extra cycle
    localparam int unsigned QUAL_CYCLES     = (CLK_HZ / 1000) * QUAL_TIME_MS;

    // ------------------------------------------------------------
    // current codes, unit 0.1 A
    // ------------------------------------------------------------
    localparam logic [15:0] THRESH_OFF      = 16'h0000;  // 0.0 A
    localparam logic [15:0] THRESH_FORCE    = 16'h01f4;  // 50.0 A
    localparam logic [15:0] THRESH_RESET    = 16'h0000;
    localparam logic [15:0] OFFSET_RESET    = 16'h0000;  // 0.0
    localparam logic [15:0] ALARM_MODE_RESET = 16'h0000;
    localparam logic [3:0]  MODE_DISABLE    = 4'hf;

    // ------------------------------------------------------------
    // control methods
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        METHOD_TIME_PROP,
        METHOD_POSITION,
        METHOD_CYCLE
    } method_type;

    // ------------------------------------------------------------
    // register offsets (word addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_ALARM_MODE   = 8'h00;
    localparam logic [7:0] REG_HALT         = 8'h01;
    localparam logic [7:0] REG_IRQ_STATUS   = 8'h02;
    localparam logic [7:0] REG_IRQ_CLEAR    = 8'h03;
    localparam logic [7:0] REG_IRQ_ENABLE   = 8'h04;
    localparam logic [7:0] REG_FAULT        = 8'h05;
    // per loop block: base + 8*loop
    localparam logic [7:0] REG_LOOP_BASE    = 8'h10;
    localparam logic [7:0] LOOP_STRIDE      = 8'h08;
    localparam logic [7:0] REG_THRESH       = 8'h00;
    localparam logic [7:0] REG_OFFSET       = 8'h01;
    localparam logic [7:0] REG_CURRENT      = 8'h02;
    localparam logic [7:0] REG_PV           = 8'h03;
    localparam logic [7:0] REG_STATUS       = 8'h04;
    localparam logic [7:0] REG_METHOD       = 8'h05;

    // ------------------------------------------------------------
    // loop status word bits
    // ------------------------------------------------------------
    localparam int unsigned ST_OPEN_BIT     = 2;
    localparam int unsigned ST_OUTPUT_BIT   = 4;
    localparam int unsigned ST_STOP_BIT     = 8;
    localparam int unsigned ST_SENSOR_BIT   = 14;

    // interrupt status bits: per loop, burnout at 2*i, sensor at 2*i+1
    localparam int unsigned IRQ_BITS        = 4;

endpackage

// >>> bench/heater_loop_supervisor_props.sv
/*
 * port-level checker for the two-loop heater supervisor.
 * assumes it is bound into the supervisor and sees host writes on its port.
 */
`timescale 1ns/1ps
module heater_loop_supervisor_chk #(
    parameter int unsigned QUAL_CYCLES = 20,
    parameter int unsigned LOOPS       = 2
) (
    // clock and reset
    input wire logic                sys_clk,
    input wire logic                rst_b,
    // register port
    input wire logic [7:0]          reg_addr,
    input wire logic [15:0]         reg_wdata,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [15:0]         reg_rdata,
    // measurement and demand
    input wire logic [LOOPS*16-1:0] current_sense_transformer,
    input wire logic [LOOPS*16-1:0] raw_pv,
    input wire logic [LOOPS-1:0]    sensor_open,
    input wire logic [LOOPS-1:0]    output_demand,
    // outputs
    input wire logic [LOOPS-1:0]    control_out,
    input wire logic [LOOPS-1:0]    heater_open_alarm,
    input wire logic                unit_fault_lamp,
    input wire logic                irq
);
    // ------------------------------------------------------------
    // shadow settings
    // ------------------------------------------------------------
    logic [15:0] thr0;
    logic [15:0] mode;
    logic        halt0;
    int unsigned on_cnt;

    // snooped from host writes, so nothing inside the block is peeked at
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
        begin
            thr0  <= 16'h0000;
            mode  <= 16'h0000;
            halt0 <= 1'b0;
        end
        else if (reg_wr)
            case (reg_addr)
                8'h00:   mode  <= reg_wdata;
                8'h01:   halt0 <= reg_wdata[0];
                8'h10:   thr0  <= reg_wdata;
                default: ;
            endcase

    // run length of loop 0 drive, a counter instead of a long repetition
    always_ff @(posedge sys_clk or negedge rst_b)
        if (!rst_b)
            on_cnt <= 0;
        else
            on_cnt <= control_out[0] ? on_cnt + 1 : 0;

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_qual;
        $rose(heater_open_alarm[0]) && thr0 < 16'h01f4 && $past(thr0) < 16'h01f4
            |-> on_cnt > QUAL_CYCLES;
    endproperty
    a_qual: assert property (p_qual)
        else $error("open alarm rose before drive was qualified");
    property p_latch;
        $fell(heater_open_alarm[0]) |-> $past(thr0) == 16'h0000 || $past(mode[15:8]) == 8'hff;
    endproperty
    a_latch: assert property (p_latch)
        else $error("open alarm dropped without clear");
    property p_zero_thr;
        thr0 == 16'h0000 && $past(thr0) == 16'h0000 |-> !heater_open_alarm[0];
    endproperty
    a_zero_thr: assert property (p_zero_thr)
        else $error("open alarm set with zero threshold");
    property p_force;
        thr0 >= 16'h01f4 && $past(thr0) >= 16'h01f4 && mode[15:8] != 8'hff
            && $past(mode[15:8]) != 8'hff |-> heater_open_alarm[0];
    endproperty
    a_force: assert property (p_force)
        else $error("open alarm not forced at top threshold");
    property p_halt;
        halt0 && $past(halt0) |-> !control_out[0];
    endproperty
    a_halt: assert property (p_halt)
        else $error("halted loop still driving");
    property p_lamp;
        unit_fault_lamp |-> |$past(sensor_open, 3);
    endproperty
    a_lamp: assert property (p_lamp)
        else $error("fault lamp without open sensor");
    property p_dis_first;
        mode[15:8] == 8'hff && $past(mode[15:8]) == 8'hff
            |-> !control_out[0] && !heater_open_alarm[0];
    endproperty
    a_dis_first: assert property (p_dis_first)
        else $error("disabled first loop still active");
    property p_dis_second;
        mode[7:0] == 8'hff && $past(mode[7:0]) == 8'hff |-> !control_out[1];
    endproperty
    a_dis_second: assert property (p_dis_second)
        else $error("disabled second loop still driving");
endmodule

bind heater_loop_supervisor heater_loop_supervisor_chk #(
    .QUAL_CYCLES(QUAL_CYCLES),
    .LOOPS(LOOPS)
) chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .current_sense_transformer(current_sense_transformer), .raw_pv(raw_pv),
    .sensor_open(sensor_open), .output_demand(output_demand), .control_out(control_out),
    .heater_open_alarm(heater_open_alarm), .unit_fault_lamp(unit_fault_lamp), .irq(irq)
);

// >>> bench/heater_plant_model.sv
/*
 * heater and current transformer stand-in: current follows the drive.
 * assumes loop 0 sits in the low half of the packed buses.
 */
`timescale 1ns/1ps
module heater_plant_model (
    // clock
    input  wire logic        sys_clk,
    // drive and fault injection
    input  wire logic [1:0]  control_out,
    input  wire logic [1:0]  wire_broken,
    input  wire logic [31:0] nominal,
    // sensed current, 0.1 A steps
    output logic      [31:0] current_sense_transformer
);
    initial current_sense_transformer = 32'h0000_0000;

    // a broken wire reads zero, so the alarm sees a real drop, not a guess
    always @(posedge sys_clk)
        for (int i = 0; i < 2; i++)
            current_sense_transformer[i*16 +: 16] <=
                (control_out[i] && !wire_broken[i]) ? nominal[i*16 +: 16] : 16'h0000;
endmodule

// >>> bench/heater_loop_supervisor_tb.sv
/*
 * self-checking bench for the heater supervisor, register port tasks.
 * assumes the checker is bound and the plant model supplies current.
 */
`timescale 1ns/1ps
module heater_loop_supervisor_tb;
    localparam int unsigned QUAL = 20;
    localparam logic [7:0]  ZREG [9] = '{8'h00, 8'h01, 8'h04, 8'h10, 8'h11, 8'h14,
                                         8'h18, 8'h19, 8'h1c};
    logic        sys_clk;
    logic        rst_b;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic [31:0] current_sense_transformer;
    logic [31:0] raw_pv;
    logic [1:0]  sensor_open;
    logic [1:0]  output_demand;
    logic [1:0]  control_out;
    logic [1:0]  heater_open_alarm;
    logic        unit_fault_lamp;
    logic        irq;
    logic [1:0]  wire_broken;
    int          mismatches;
    int          n_checks;

    // 40 MHz
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    heater_loop_supervisor #(.QUAL_CYCLES(QUAL), .LOOPS(2)) uut (
        .sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .current_sense_transformer(current_sense_transformer), .raw_pv(raw_pv),
        .sensor_open(sensor_open), .output_demand(output_demand), .control_out(control_out),
        .heater_open_alarm(heater_open_alarm), .unit_fault_lamp(unit_fault_lamp), .irq(irq)
    );

    heater_plant_model plant (
        .sys_clk(sys_clk), .control_out(control_out), .wire_broken(wire_broken),
        .nominal({16'h00c8, 16'h0064}), .current_sense_transformer(current_sense_transformer)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // waits land one step past the edge so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rdc(input logic [7:0] a, input logic [15:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    task automatic summarize;
        if (mismatches == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial
    begin
        {rst_b, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        {sensor_open, output_demand, wire_broken, mismatches, n_checks} = '0;
        raw_pv = {16'h0010, 16'h07d0};
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 9; i++)
            rdc(ZREG[i], 16'h0000);
        wr(8'h11, 16'h000c);
        wr(8'h19, 16'hfff6);
        rdc(8'h13, 16'h07dc);
        rdc(8'h1b, 16'h0006);
        @(posedge sys_clk);
        output_demand <= 2'b11;
        cyc(QUAL + 10);
        rdc(8'h12, 16'h0064);
        rdc(8'h1a, 16'h00c8);
        rdc(8'h14, 16'h0010);
        wr(8'h12, 16'h5555);
        rdc(8'h12, 16'h0064);
        rdc(8'h3f, 16'h0000);
        // drive gap restarts qualification while the wire is already open
        wr(8'h04, 16'h000f);
        wr(8'h10, 16'h0050);
        wr(8'h18, 16'h0050);
        @(posedge sys_clk);
        wire_broken   <= 2'b01;
        output_demand <= 2'b10;
        @(posedge sys_clk);
        output_demand <= 2'b11;
        cyc(QUAL - 4);
        check({14'h0, heater_open_alarm}, 16'h0000);
        cyc(14);
        check({14'h0, heater_open_alarm}, 16'h0001);
        check({14'h0, control_out}, 16'h0003);
        rdc(8'h14, 16'h0014);
        check({15'h0, irq}, 16'h0001);
        wr(8'h04, 16'h0000);
        cyc(2);
        check({15'h0, irq}, 16'h0000);
        wr(8'h04, 16'h000f);
        rdc(8'h02, 16'h0001);
        wr(8'h03, 16'h0001);
        cyc(2);
        check({15'h0, irq}, 16'h0000);
        @(posedge sys_clk);
        wire_broken <= 2'b00;
        cyc(10);
        check({14'h0, heater_open_alarm}, 16'h0001);
        wr(8'h10, 16'h0000);
        cyc(3);
        check({14'h0, heater_open_alarm}, 16'h0000);
        wr(8'h10, 16'h01f4);
        cyc(3);
        check({14'h0, heater_open_alarm}, 16'h0001);
        wr(8'h10, 16'h0000);
        for (int m = 1; m < 3; m++)
        begin
            wr(8'h15, 16'(m));
            wr(8'h10, 16'h0050);
            wire_broken <= 2'b01;
            cyc(QUAL + 10);
            check({14'h0, heater_open_alarm}, 16'h0000);
            wire_broken <= 2'b00;
            wr(8'h10, 16'h0000);
        end
        wr(8'h15, 16'h0000);
        wr(8'h01, 16'h0001);
        cyc(3);
        check({14'h0, control_out}, 16'h0002);
        rdc(8'h14, 16'h0100);
        wr(8'h01, 16'h0000);
        cyc(3);
        check({14'h0, control_out}, 16'h0003);
        wr(8'h18, 16'h00d0);
        cyc(3);
        check({14'h0, heater_open_alarm}, 16'h0002);
        @(posedge sys_clk);
        sensor_open <= 2'b10;
        cyc(5);
        rdc(8'h05, 16'h0001);
        rdc(8'h1c, 16'h4014);
        wr(8'h00, 16'h00ff);
        cyc(3);
        check({13'h0, unit_fault_lamp, control_out}, 16'h0001);
        wr(8'h00, 16'hff00);
        cyc(3);
        check({13'h0, unit_fault_lamp, control_out}, 16'h0006);
        rdc(8'h13, 16'h07dc);
        summarize();
    end

    // hang guard, well beyond the few hundred cycles the run needs
    initial
    begin
        repeat (5000) @(posedge sys_clk);
        mismatches++;
        summarize();
    end
endmodule
